/* stec_regs.vh */
// Purpose: Register offsets, field positions and reset values for the 16-bit timer/event counter
// Assumes: AHB-Lite word registers, byte addresses
// Notes:   Definitions only
`ifndef STEC_REGS_VH
`define STEC_REGS_VH
// Register byte offsets
`define STEC_OFF_COUNT   8'h00
`define STEC_OFF_CC0     8'h04
`define STEC_OFF_CC1     8'h08
`define STEC_OFF_CTRL    8'h0C
`define STEC_OFF_CCCTRL  8'h10
`define STEC_OFF_EDGE    8'h14
`define STEC_OFF_STATUS  8'h18
// Control register fields
`define STEC_CTRL_MODE_LSB  0
`define STEC_CTRL_MODE_MSB  1
`define STEC_CTRL_CLK_LSB   2
`define STEC_CTRL_CLK_MSB   4
`define STEC_CTRL_OUTEN     5
`define STEC_CTRL_OUTINV    6
`define STEC_CTRL_OUTMODE_LSB 7
`define STEC_CTRL_OUTMODE_MSB 8
`define STEC_CTRL_ONESHOT   9
`define STEC_CTRL_RESET     10'h000
// Capture/compare control fields
`define STEC_CC_ZERO_MODE   0
`define STEC_CC_ZERO_SRC    1
`define STEC_CC_ONE_MODE    2
`define STEC_CCCTRL_RESET   3'h0
// Edge select fields
`define STEC_EDGE_A_LSB     0
`define STEC_EDGE_A_MSB     1
`define STEC_EDGE_B_LSB     2
`define STEC_EDGE_B_MSB     3
`define STEC_EDGE_RESET     4'h0
// Mode codes
`define STEC_MODE_STOP      2'h0
`define STEC_MODE_FREE      2'h1
`define STEC_MODE_CLR_MATCH 2'h2
`define STEC_MODE_CLR_EDGE  2'h3
// Output modes
`define STEC_OUT_TOGGLE     2'h0
`define STEC_OUT_PWM        2'h1
`define STEC_OUT_ONESHOT    2'h2
// Count clock sources
`define STEC_CLK_EDGE_A     3'h0
`define STEC_CLK_WATCH      3'h7
`define STEC_COUNT_RESET    16'h0000
`endif

/* stec_timer.v */
// Purpose: 16-bit timer/event counter with two capture/compare registers and one timer output
// Assumes: AHB-Lite slave, one clock, zero-wait answers, pins synchronised here
// Notes:   Notes on behaviour follow
// Overview
// The count register advances on at most one selected count tick per sys
// clock, so the fastest count rate equals the system clock.  Every pin that
// can produce a tick or a capture first passes a two-stage synchroniser and
// an edge detector.  An edge therefore acts about three clocks after the pin
// moves, and pulses shorter than one clock may be lost.
// Compare matches are judged on the tick that leaves the matching value.
// This makes the interval in clear-on-match mode exactly compare plus one
// ticks, and it lets a zero compare in free mode fire only after the wrap.
// Both capture/compare registers skip reset on purpose: software must load
// them before use, and nothing here relies on their state after reset.
// Trade-off: the bus answers with no wait state, so read data is taken at
// the address phase, one clock before the data phase ends.
//
`timescale 1ns/1ns
`default_nettype none
`include "stec_regs.vh"
module stec_timer #(
  parameter DIV_BITS = 4              // Width of the main clock prescaler
) (
  input  wire        sys_clk_in,      // System clock, 10 MHz
  input  wire        nrst_in,         // Asynchronous reset, active low
  input  wire        hsel_in,         // AHB select
  input  wire [31:0] haddr_in,        // AHB address
  input  wire [1:0]  htrans_in,       // AHB transfer type
  input  wire        hwrite_in,       // AHB write
  input  wire [2:0]  hsize_in,        // AHB size
  input  wire [31:0] hwdata_in,       // AHB write data
  input  wire        hready_in,       // AHB bus ready
  output reg  [31:0] hrdata_out,      // AHB read data
  output wire        hreadyout_out,   // AHB slave ready
  output wire        hresp_out,       // AHB response
  input  wire        timer_input_a_in, // External input a (capture, count clock)
  input  wire        timer_input_b_in, // External input b (capture)
  input  wire        watch_tick_in,   // Watch timer output
  output reg         timer_output_pin_out, // Timer output level
  output reg         match_zero_irq_out,   // Match-zero request pulse
  output reg         match_one_irq_out     // Match-one request pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Edge decode for input a: rising, falling, or none (11); 10 treated as none
  function cap_a_fn;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        2'h0:    cap_a_fn = rise;
        2'h1:    cap_a_fn = fall;
        default: cap_a_fn = 1'b0;
      endcase
    end
  endfunction

  // Pin valid edge decode: 00 fall, 01 rise, 11 both; 10 treated as none
  // Shared by the count clock, the clear-on-edge mode, capture one and the
  // input b source of capture zero; capture zero from input a uses cap_a_fn.
  function pin_edge_fn;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        2'h0:    pin_edge_fn = fall;
        2'h1:    pin_edge_fn = rise;
        2'h3:    pin_edge_fn = rise | fall;
        default: pin_edge_fn = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Register map in brief: count at the lowest word (any write restarts),
  // compare zero, compare one, control, capture/compare control, edge
  // selects, then a read-only status word with the synchronised pins.
  // Unmapped offsets read as zero and ignore writes.
  reg  [15:0] count_register;           // Running count
  reg  [15:0] capture_compare_zero;     // No reset value by design
  reg  [15:0] capture_compare_one;      // Second capture/compare register
  reg  [9:0]  ctrl;                     // Mode, clock, output control
  reg  [2:0]  capture_compare_control;  // Capture/compare modes
  reg  [3:0]  ext_irq_mode_reg;         // Edge select fields
  reg  [1:0]  sync_a;                   // Input a synchroniser
  reg  [1:0]  sync_b;                   // Input b synchroniser
  reg  [1:0]  sync_w;                   // Watch synchroniser
  reg         prev_a;                   // Last synced input a
  reg         prev_b;                   // Last synced input b
  reg         prev_w;                   // Last synced watch
  reg  [DIV_BITS-1:0] prescale;         // Main clock divider
  reg         oneshot_done;             // One-shot already fired
  reg         restart;                  // Software restart request
  reg         ph_act;                   // Data phase pending
  reg         ph_wr;                    // Pending is a write
  reg  [7:0]  ph_addr;                  // Pending byte offset

  wire [1:0] mode     = ctrl[`STEC_CTRL_MODE_MSB:`STEC_CTRL_MODE_LSB];
  wire [2:0] clk_sel  = ctrl[`STEC_CTRL_CLK_MSB:`STEC_CTRL_CLK_LSB];
  wire [1:0] out_mode = ctrl[`STEC_CTRL_OUTMODE_MSB:`STEC_CTRL_OUTMODE_LSB];
  wire [1:0] edge_a   = ext_irq_mode_reg[`STEC_EDGE_A_MSB:`STEC_EDGE_A_LSB];
  wire [1:0] edge_b   = ext_irq_mode_reg[`STEC_EDGE_B_MSB:`STEC_EDGE_B_LSB];
  wire cc0_capture = capture_compare_control[`STEC_CC_ZERO_MODE];
  wire cc1_capture = capture_compare_control[`STEC_CC_ONE_MODE];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read by logic
  // The edge detectors reset low, matching the idle level of the pins, so a
  // pin that idles low gives no false edge after reset.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      sync_w <= 2'h0;
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      prev_w <= 1'b0;
    end else begin
      sync_a <= {sync_a[0], timer_input_a_in};
      sync_b <= {sync_b[0], timer_input_b_in};
      sync_w <= {sync_w[0], watch_tick_in};
      prev_a <= sync_a[1];
      prev_b <= sync_b[1];
      prev_w <= sync_w[1];
    end
  end

  wire rise_a = sync_a[1] & ~prev_a;
  wire fall_a = ~sync_a[1] & prev_a;
  wire rise_b = sync_b[1] & ~prev_b;
  wire fall_b = ~sync_b[1] & prev_b;
  wire valid_a = pin_edge_fn(edge_a, rise_a, fall_a); // Pin a valid edge
  wire valid_b = pin_edge_fn(edge_b, rise_b, fall_b); // Pin b valid edge

  ////////////////////////////////////////////////////////////////////////////
  // Count clock selection: code 1..5 picks 2^(code-1) division of sys clock
  wire [DIV_BITS:0] div_ext = {1'b0, prescale};
  reg count_tick;
  always @* begin
    case (clk_sel)
      `STEC_CLK_EDGE_A: count_tick = valid_a;
      `STEC_CLK_WATCH:  count_tick = sync_w[1] & ~prev_w;
      3'h1:    count_tick = 1'b1;
      3'h2:    count_tick = (div_ext[0] == 1'b1);
      3'h3:    count_tick = (div_ext[1:0] == 2'h3);
      3'h4:    count_tick = (div_ext[2:0] == 3'h7);
      3'h5:    count_tick = (div_ext[3:0] == 4'hF);
      default: count_tick = 1'b0;                      // Prohibited codes stall
    endcase
  end

  // Free-running prescaler; limitation: codes above DIV_BITS+1 stall, so code 5 needs DIV_BITS >= 4
  // The prescaler never stops, so the first tick after a clock change may
  // come early by up to one divided period; software should stop the timer
  // before it rewrites the clock select.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      prescale <= {DIV_BITS{1'b0}};
    else
      prescale <= prescale + {{(DIV_BITS-1){1'b0}}, 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and capture events
  // Capture mode disables the compare path of the same register, so that a
  // captured value can never raise a stale match request.
  // Register one captures on the valid edge of input a only.
  wire running  = (mode != `STEC_MODE_STOP);
  wire match0   = running & ~cc0_capture & (count_register == capture_compare_zero);
  wire match1   = running & ~cc1_capture & (count_register == capture_compare_one);
  wire cap0_trig = capture_compare_control[`STEC_CC_ZERO_SRC] ?
                   pin_edge_fn(edge_b, rise_b, fall_b) :
                   cap_a_fn(edge_a, rise_a, fall_a);
  wire cap1_trig = valid_a;
  // Match is seen once per count value, on the tick that leaves it, so a zero
  // compare in free mode fires only after FFFF wraps to 0000 and is left.
  wire hit0 = match0 & count_tick;
  wire hit1 = match1 & count_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Count register: clear on match zero, on valid edge a, or on restart
  // Priority: stop or restart, then clear on a valid input a edge, then
  // clear on match zero, then the plain tick.  Clear on edge is ignored when
  // input a is itself the count clock, since the same edge would both count
  // and clear.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_register <= `STEC_COUNT_RESET;
    end else if (!running || restart) begin
      count_register <= `STEC_COUNT_RESET;
    end else if (mode == `STEC_MODE_CLR_EDGE && valid_a && clk_sel != `STEC_CLK_EDGE_A) begin
      count_register <= `STEC_COUNT_RESET;
    end else if (mode == `STEC_MODE_CLR_MATCH && hit0) begin
      count_register <= `STEC_COUNT_RESET;
    end else if (count_tick) begin
      count_register <= count_register + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request pulses, one sys clock each
  // Registered so that the requests are free of decode glitches; they lag
  // the matching tick by one clock.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      match_zero_irq_out <= 1'b0;
      match_one_irq_out  <= 1'b0;
    end else begin
      match_zero_irq_out <= hit0;
      match_one_irq_out  <= hit1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer output: toggle (square wave), PWM, one-shot; capture runs alongside
  // The output is parked at the invert level while disabled or stopped, so
  // enabling it never begins with a level of the wrong polarity.  The
  // one-shot fires once per run; stopping the timer re-arms it.
  wire pwm_level = (count_register[15:2] < capture_compare_zero[15:2]);
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_output_pin_out <= 1'b0;
      oneshot_done         <= 1'b0;
    end else if (!ctrl[`STEC_CTRL_OUTEN] || !running) begin
      timer_output_pin_out <= ctrl[`STEC_CTRL_OUTINV];
      oneshot_done         <= 1'b0;
    end else begin
      case (out_mode)
        `STEC_OUT_TOGGLE: begin
          if (hit0)
            timer_output_pin_out <= ~timer_output_pin_out;
        end
        `STEC_OUT_PWM: begin
          timer_output_pin_out <= pwm_level ^ ctrl[`STEC_CTRL_OUTINV];
        end
        `STEC_OUT_ONESHOT: begin
          // High from start until compare one, then low until re-armed
          if (hit1 || oneshot_done) begin
            timer_output_pin_out <= ctrl[`STEC_CTRL_OUTINV];
            oneshot_done         <= 1'b1;
          end else if (ctrl[`STEC_CTRL_ONESHOT]) begin
            timer_output_pin_out <= ~ctrl[`STEC_CTRL_OUTINV];
          end
        end
        default: begin
          timer_output_pin_out <= ctrl[`STEC_CTRL_OUTINV];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture; answers with no wait state
  // Only the low address byte is decoded and hsize is ignored, because every
  // register is one aligned word.  Write data is taken in the data phase.
  wire take = hsel_in & htrans_in[1] & hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ph_act  <= 1'b0;
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_act  <= take;
      ph_wr   <= take & hwrite_in;
      ph_addr <= haddr_in[7:0];
    end
  end

  wire wr_cc0 = ph_act & ph_wr & (ph_addr == `STEC_OFF_CC0);
  wire wr_cc1 = ph_act & ph_wr & (ph_addr == `STEC_OFF_CC1);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers written by software
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl                    <= `STEC_CTRL_RESET;
      capture_compare_control <= `STEC_CCCTRL_RESET;
      ext_irq_mode_reg        <= `STEC_EDGE_RESET;
      restart                 <= 1'b0;
    end else begin
      // Writing the count register restarts from zero (used after lowering CC0)
      restart <= ph_act & ph_wr & (ph_addr == `STEC_OFF_COUNT);
      if (ph_act && ph_wr) begin
        case (ph_addr)
          `STEC_OFF_CTRL:   ctrl <= hwdata_in[9:0];
          `STEC_OFF_CCCTRL: capture_compare_control <= hwdata_in[2:0];
          `STEC_OFF_EDGE:   ext_irq_mode_reg <= hwdata_in[3:0];
          default: ;
        endcase
      end
    end
  end

  // Capture/compare zero: deliberately no reset, software must program it
  // A capture beats a software write in the same cycle, so a measurement is
  // never lost to a late reprogramming of the register.
  always @(posedge sys_clk_in) begin
    if (cc0_capture && cap0_trig)
      capture_compare_zero <= count_register;
    else if (wr_cc0)
      capture_compare_zero <= hwdata_in[15:0];
  end

  // Capture/compare one: capture wins over a software write
  always @(posedge sys_clk_in) begin
    if (cc1_capture && cap1_trig)
      capture_compare_one <= count_register;
    else if (wr_cc1)
      capture_compare_one <= hwdata_in[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered at the address phase; unmapped reads return zero
  // The status word shows the synchronised pin levels, not the raw pins.
  // Read data stands until the next read is taken, as the bus permits.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (take && !hwrite_in) begin
      case (haddr_in[7:0])
        `STEC_OFF_COUNT:  hrdata_out <= {16'h0000, count_register};
        `STEC_OFF_CC0:    hrdata_out <= {16'h0000, capture_compare_zero};
        `STEC_OFF_CC1:    hrdata_out <= {16'h0000, capture_compare_one};
        `STEC_OFF_CTRL:   hrdata_out <= {22'h000000, ctrl};
        `STEC_OFF_CCCTRL: hrdata_out <= {29'h00000000, capture_compare_control};
        `STEC_OFF_EDGE:   hrdata_out <= {28'h0000000, ext_irq_mode_reg};
        `STEC_OFF_STATUS: hrdata_out <= {29'h00000000, oneshot_done, sync_b[1], sync_a[1]};
        default:          hrdata_out <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* stec_timer_assertions.sv */
// Purpose: Port-level checks for the timer block
// Assumes: Zero-wait bus slave; control and compare zero are shadowed from bus writes
// Notes:   Bound to every instance of the timer
`timescale 1ns/1ns
`default_nettype none
module stec_timer_checker (
  input wire logic        sys_clk_in,           // System clock
  input wire logic        nrst_in,              // Reset, active low
  input wire logic        hsel_in,              // Bus select
  input wire logic [31:0] haddr_in,             // Bus address
  input wire logic [1:0]  htrans_in,            // Transfer type
  input wire logic        hwrite_in,            // Write flag
  input wire logic [31:0] hwdata_in,            // Write data
  input wire logic        hready_in,            // Bus ready
  input wire logic [31:0] hrdata_out,           // Read data
  input wire logic        hreadyout_out,        // Slave ready
  input wire logic        hresp_out,            // Slave response
  input wire logic        timer_output_pin_out, // Timer output
  input wire logic        match_zero_irq_out,   // Match-zero pulse
  input wire logic        match_one_irq_out     // Match-one pulse
);
  ////////////////////////////////////////////////////////////////////////////////
  logic        wr_pend; // Write data phase due
  logic [7:0]  wr_addr; // Offset of that write
  logic [9:0]  ctrl_sh; // Control as last written
  logic [15:0] cc0_sh;  // Compare zero as last written
  wire         take = hsel_in && htrans_in[1] && hready_in;              // Transfer accepted
  wire         run4 = (ctrl_sh[4:0] == 5'h06) && (cc0_sh == 16'h0003); // Four-cycle interval
  // Shadow copies; captures are never enabled while run4 holds, so writes suffice
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ctrl_sh <= 10'h000;
      cc0_sh  <= 16'h0000;
    end else if (hready_in) begin
      wr_pend <= take && hwrite_in;
      wr_addr <= haddr_in[7:0];
      if (wr_pend && wr_addr == 8'h0C) begin
        ctrl_sh <= hwdata_in[9:0];
      end
      if (wr_pend && wr_addr == 8'h04) begin
        cc0_sh <= hwdata_in[15:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  ready_high_a: assert property (hreadyout_out)
    else $error("slave inserted a wait state");
  okay_resp_a: assert property (!hresp_out)
    else $error("slave gave an error response");
  rst_clean_a: assert property (
    $rose(nrst_in) |-> hrdata_out == 32'h0 && !match_zero_irq_out && !timer_output_pin_out)
    else $error("outputs not quiet after reset");
  upper_zero_a: assert property (
    take && !hwrite_in |=> hrdata_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  unmapped_read_a: assert property (take && !hwrite_in && haddr_in[7:0] == 8'h1C |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  zero_pulse_a: assert property (match_zero_irq_out |=> !match_zero_irq_out)
    else $error("match-zero pulse too long");
  one_pulse_a: assert property (match_one_irq_out |=> !match_one_irq_out)
    else $error("match-one pulse too long");
  no_early_a: assert property (match_zero_irq_out && run4 |=> (!match_zero_irq_out)[*3])
    else $error("interval request came early");
  on_time_a: assert property (match_zero_irq_out && run4 ##1 run4[*4] |-> match_zero_irq_out)
    else $error("interval request came late");
endmodule
bind stec_timer stec_timer_checker u_stec_timer_checker (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .timer_output_pin_out(timer_output_pin_out), .match_zero_irq_out(match_zero_irq_out),
  .match_one_irq_out(match_one_irq_out));
`default_nettype wire

/* stec_pins_model.sv */
// Purpose: Far-side model: pulse sources on both inputs and the watch tick
// Assumes: Levels change by non-blocking assignment just after a clock edge
// Notes:   Pulses last at least one clock, as the synchroniser needs
`timescale 1ns/1ns
`default_nettype none
module stec_pins_model (
  input  wire logic sys_clk_in, // System clock
  output wire logic pin_a_out,  // Input a level
  output wire logic pin_b_out,  // Input b level
  output wire logic watch_out   // Watch tick level
);
  logic [2:0] lv = 3'h0; // Driven levels, all idle low
  assign pin_a_out = lv[0];
  assign pin_b_out = lv[1];
  assign watch_out = lv[2];
  // One pulse on the chosen source; held whole cycles so no edge is lost
  task automatic pulse(input int sel, input int hi, input int lo);
    lv[sel] <= 1'b1;
    repeat (hi) @(posedge sys_clk_in);
    lv[sel] <= 1'b0;
    repeat (lo) @(posedge sys_clk_in);
  endtask
endmodule
`default_nettype wire

/* test_stec_timer.sv */
// Purpose: Register-level tests of the timer block
// Assumes: Zero-wait bus; pin edges act a few clocks late
// Notes:   Capture checks use windows because of synchroniser delay
`timescale 1ns/1ns
`default_nettype none
module test_stec_timer;
  logic        sys_clk_in = 1'b0; // 10 MHz clock
  logic        nrst_in = 1'b0;    // Reset, active low
  logic        hsel = 1'b0;       // Bus select
  logic [31:0] haddr = 32'h0;     // Bus address
  logic [1:0]  htrans = 2'h0;     // Transfer type
  logic        hwrite = 1'b0;     // Write flag
  logic [31:0] hwdata = 32'h0;    // Write data
  logic [31:0] rd;                // Last read word
  wire  [31:0] hrdata;            // Read data
  wire         hready;            // Slave ready is bus ready
  wire         pin_a, pin_b, watch, tout, irq0; // Pins and requests
  int          fails = 0;         // Mismatches
  int          tests_run = 0;     // Comparisons
  int          cyc = 0;           // Cycles run
  int          iv[3] = '{1, 3, 7};           // Interval compare values
  int          cs[6] = '{0, 0, 0, 1, 1, 1};  // Capture source
  logic [1:0]  ec[6] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h3}; // Edge codes
  int          cx[6] = '{38, 18, 0, 18, 38, 18}; // Distance to count, 0 = no capture
  always #50 sys_clk_in = ~sys_clk_in;
  stec_timer u_stec_timer (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(), .timer_input_a_in(pin_a),
    .timer_input_b_in(pin_b), .watch_tick_in(watch), .timer_output_pin_out(tout),
    .match_zero_irq_out(irq0), .match_one_irq_out());
  stec_pins_model u_stec_pins_model (.sys_clk_in(sys_clk_in), .pin_a_out(pin_a), .pin_b_out(pin_b),
    .watch_out(watch));
  ////////////////////////////////////////////////////////////////////////////////
  // One single-word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  // Cycles up to the next match-zero request
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (irq0 !== 1'b1);
  endtask
  // Cycles until the timer output changes
  task automatic run_len(output int n);
    logic v;
    v = tout;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (tout === v);
  endtask
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, well above the long overflow wait
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int d;
    repeat (8) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    xfer(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, 8'h04, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_FFFF);
    xfer(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, 8'h08, 32'h0100);
    // Interval lengths of two, four and eight clocks; stop restarts each one
    foreach (iv[i]) begin
      xfer(1'b1, 8'h04, iv[i]);
      xfer(1'b1, 8'h0C, 32'h06);
      gap(n);
      gap(n);
      check(n, iv[i] + 1);
      xfer(1'b1, 8'h0C, 32'h0);
    end
    // Square wave: toggle on match, half period of five clocks
    xfer(1'b1, 8'h04, 32'h4);
    xfer(1'b1, 8'h0C, 32'h26);
    run_len(n);
    run_len(n);
    check(n, 5);
    xfer(1'b1, 8'h0C, 32'h0);
    // PWM duty in the upper fourteen bits, high while the count is below it
    xfer(1'b1, 8'h04, 32'h40);
    xfer(1'b1, 8'h0C, 32'hA5);
    run_len(n);
    if (tout === 1'b1) run_len(n);
    in_range(n, 60, 64);
    xfer(1'b1, 8'h0C, 32'h05);
    // Captures from both inputs under every legal edge code
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, 8'h10, (cs[i] == 1) ? 32'h3 : 32'h1);
      xfer(1'b1, 8'h14, {28'h0, ec[i], ec[i]});
      xfer(1'b1, 8'h04, 32'h1234);
      u_stec_pins_model.pulse(cs[i], 20, 20);
      xfer(1'b0, 8'h00, 32'h0);
      d = rd;
      xfer(1'b0, 8'h04, 32'h0);
      if (cx[i] == 0) check(rd, 32'h1234);
      else in_range(16'(d - rd), cx[i] - 5, cx[i] + 5);
    end
    xfer(1'b1, 8'h10, 32'h0);
    // Event counting on both edges of input a, then on watch ticks
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b1, 8'h14, 32'h3);
    xfer(1'b1, 8'h0C, 32'h01);
    repeat (5) u_stec_pins_model.pulse(0, 3, 3);
    repeat (4) @(posedge sys_clk_in);
    xfer(1'b0, 8'h00, 32'h0);
    check(rd, 32'hA);
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b1, 8'h0C, 32'h1D);
    repeat (4) u_stec_pins_model.pulse(2, 3, 3);
    repeat (4) @(posedge sys_clk_in);
    xfer(1'b0, 8'h00, 32'h0);
    check(rd, 32'h4);
    // Compare lowered below the count: no match until the count wraps
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b1, 8'h04, 32'h10);
    xfer(1'b1, 8'h0C, 32'h05);
    gap(n);
    xfer(1'b1, 8'h04, 32'h0);
    gap(n);
    in_range(n, 65510, 65530);
    // One-shot: high from the start of the run until compare one matches
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b1, 8'h08, 32'h20);
    xfer(1'b1, 8'h0C, 32'h325);
    run_len(n);
    run_len(n);
    check(n, 32);
    print_verdict();
  end
endmodule
`default_nettype wire
